// ---- hdl/stc_pkg.sv ----
package stc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] STC_TCS_OFF = 8'h00; // transmitter_control_status
    localparam logic [7:0] STC_TXB_OFF = 8'h04; // tx_holding_buffer
    localparam logic [7:0] STC_CFG_OFF = 8'h08; // sync fill character
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int STC_B_FILL = 15;
    localparam int STC_B_LOOPD = 14;
    localparam int STC_B_SSCLK = 13;
    localparam int STC_B_MODE_HI = 12;
    localparam int STC_B_MODE_LO = 11;
    localparam int STC_B_RXMON = 10;
    localparam int STC_B_CLR = 8;
    localparam int STC_B_DONE = 7;
    localparam int STC_B_DONE_IE = 6;
    localparam int STC_B_FILL_IE = 5;
    localparam int STC_B_SEND = 4;
    localparam int STC_B_HDX = 3;
    localparam int STC_B_BREAK = 0;
    // ------------------------------------------------------------
    // reset values and modes
    // ------------------------------------------------------------
    localparam logic [7:0] STC_TXB_RST = 8'hff;
    localparam logic [7:0] STC_FILL_RST = 8'h16;
    localparam logic [1:0] STC_MODE_NORMAL = 2'h0;
    localparam logic [1:0] STC_MODE_INT_LOOP = 2'h1;
    localparam logic [1:0] STC_MODE_EXT_LOOP = 2'h2;
    localparam logic [1:0] STC_MODE_SYS_TEST = 2'h3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int STC_CLK_PS = 5000;
    localparam int STC_CLR_PULSE_NS = 3000;
    localparam int STC_CLR_CYC = (STC_CLR_PULSE_NS * 1000) / STC_CLK_PS;
    localparam int STC_BIT_CYC_DEF = 16;
endpackage

// ---- hdl/stc_txcs.sv ----
`timescale 1ns/100ps
// Operation
// - single-step bit clocks link in loop modes
// - two-bit loop mode field, reset clears
// - done sets on reset and first bit
// - done set with enable raises request
// - done read-only, cleared by buffer load
// - done enable gates done request
// - fill enable gates fill-sent request
// - send enables transmit after buffer load
// - send cleared: finish character, then idle
// - enables and send read/write, reset clears
// - one-way turnaround disables receiver while sending
// - fill character sent sets fill flag
// - loop data drives receiver input in loops
module stc_txcs
    import stc_pkg::*;
#(
    parameter int BIT_CYC = STC_BIT_CYC_DEF,
    parameter int CLR_CYC = STC_CLR_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial line
    input wire logic line_rx_i,
    output logic line_tx_o,
    // receiver side
    output logic rx_serial_o,
    output logic rx_bit_clk_o,
    output logic rx_enable_o,
    output logic loop_mode_o,
    // transmitter interrupt request
    output logic tx_irq_o
);
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_DATA = 3'b010,
        TX_FILL = 3'b100
    } stc_tx_state_t;

    typedef struct packed {
        logic fill_sent_flag;
        logic loop_serial_input;
        logic ss_clk;
        logic [1:0] loop_mode_select;
        logic soft_clear;
        logic tx_done;
        logic tx_taken_irq_en;
        logic fill_irq_en;
        logic send;
        logic one_way_turnaround;
        logic brk;
        logic [7:0] tx_holding_buffer;
        logic buf_full;
        logic [7:0] fill_char;
        logic [7:0] shreg;
        logic [3:0] bits_left;
        logic [15:0] bit_cnt;
        logic [15:0] clr_cnt;
        logic ss_prev;
        stc_tx_state_t tx_st;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic line_tx;
        logic rx_serial;
        logic rx_bit_clk;
        logic rx_enable;
        logic loop_mode;
        logic tx_irq;
    } stc_state_t;

    stc_state_t s_q;
    stc_state_t s_d;

    function automatic stc_state_t init_state(input stc_state_t cur);
        stc_state_t r;
        r = '0;
        r.tx_done = 1'b1;
        r.tx_holding_buffer = STC_TXB_RST;
        r.fill_char = cur.fill_char;
        r.tx_st = TX_IDLE;
        r.line_tx = 1'b1;
        r.rx_serial = 1'b1;
        r.rx_enable = 1'b1;
        return r;
    endfunction

    logic loop_on;
    logic tick;
    logic load;
    logic acc;
    logic [15:0] csr;
    logic rx_level;

    always_comb begin
        s_d = s_q;
        loop_on = (s_q.loop_mode_select == STC_MODE_INT_LOOP) ||
                 (s_q.loop_mode_select == STC_MODE_EXT_LOOP);
        rx_level = loop_on ? s_q.loop_serial_input : line_rx_i;
        csr = '0;
        csr[STC_B_FILL] = s_q.fill_sent_flag;
        csr[STC_B_LOOPD] = s_q.loop_serial_input;
        csr[STC_B_SSCLK] = s_q.ss_clk;
        csr[STC_B_MODE_HI:STC_B_MODE_LO] = s_q.loop_mode_select;
        csr[STC_B_RXMON] = rx_level;
        csr[STC_B_CLR] = s_q.soft_clear;
        csr[STC_B_DONE] = s_q.tx_done;
        csr[STC_B_DONE_IE] = s_q.tx_taken_irq_en;
        csr[STC_B_FILL_IE] = s_q.fill_irq_en;
        csr[STC_B_SEND] = s_q.send;
        csr[STC_B_HDX] = s_q.one_way_turnaround;
        csr[STC_B_BREAK] = s_q.brk;
        // bit timing: free counter in normal, single-step edge in loops
        if (loop_on) begin
            tick = s_q.ss_clk && !s_q.ss_prev;
        end else begin
            tick = (s_q.bit_cnt == 16'(BIT_CYC - 1));
        end
        s_d.ss_prev = s_q.ss_clk;
        s_d.bit_cnt = (loop_on || tick) ? '0 : s_q.bit_cnt + 16'h0001;
        // ------------------------------------------------------------
        // apb access
        // ------------------------------------------------------------
        acc = psel_i && penable_i && !s_q.pready && !s_q.soft_clear;
        load = 1'b0;
        s_d.pready = acc;
        s_d.pslverr = 1'b0;
        if (acc && pwrite_i) begin
            if (paddr_i == STC_TCS_OFF) begin
                s_d.loop_serial_input = pwdata_i[STC_B_LOOPD];
                s_d.ss_clk = pwdata_i[STC_B_SSCLK];
                s_d.loop_mode_select = pwdata_i[STC_B_MODE_HI:STC_B_MODE_LO];
                s_d.tx_taken_irq_en = pwdata_i[STC_B_DONE_IE];
                s_d.fill_irq_en = pwdata_i[STC_B_FILL_IE];
                s_d.send = pwdata_i[STC_B_SEND];
                s_d.one_way_turnaround = pwdata_i[STC_B_HDX];
                s_d.brk = pwdata_i[STC_B_BREAK];
                if (pwdata_i[STC_B_CLR]) begin
                    s_d.soft_clear = 1'b1;
                    s_d.clr_cnt = '0;
                end
            end else if (paddr_i == STC_TXB_OFF) begin
                load = 1'b1;
                s_d.tx_holding_buffer = pwdata_i[7:0];
                s_d.buf_full = 1'b1;
                s_d.tx_done = 1'b0;
            end else if (paddr_i == STC_CFG_OFF) begin
                s_d.fill_char = pwdata_i[7:0];
            end else begin
                s_d.pslverr = 1'b1;
            end
        end else if (acc) begin
            if (paddr_i == STC_TCS_OFF) begin
                s_d.prdata = {16'h0000, csr};
                s_d.fill_sent_flag = 1'b0;
            end else if (paddr_i == STC_CFG_OFF) begin
                s_d.prdata = {24'h000000, s_q.fill_char};
            end else if (paddr_i == STC_TXB_OFF) begin
                s_d.prdata = '0;
            end else begin
                s_d.prdata = '0;
                s_d.pslverr = 1'b1;
            end
        end
        // ------------------------------------------------------------
        // transmitter
        // ------------------------------------------------------------
        if (tick) begin
            if (s_q.bits_left != 4'h0) begin
                s_d.line_tx = s_q.shreg[0];
                s_d.shreg = {1'b1, s_q.shreg[7:1]};
                s_d.bits_left = s_q.bits_left - 4'h1;
            end else if (s_q.buf_full && s_q.send && !load) begin
                s_d.tx_st = TX_DATA;
                s_d.line_tx = s_q.tx_holding_buffer[0];
                s_d.shreg = {1'b1, s_q.tx_holding_buffer[7:1]};
                s_d.bits_left = 4'h7;
                s_d.buf_full = 1'b0;
                s_d.tx_done = 1'b1;
            end else if (s_q.send && s_q.tx_st != TX_IDLE) begin
                s_d.tx_st = TX_FILL;
                s_d.line_tx = s_q.fill_char[0];
                s_d.shreg = {1'b1, s_q.fill_char[7:1]};
                s_d.bits_left = 4'h7;
                s_d.fill_sent_flag = 1'b1;
            end else begin
                s_d.tx_st = TX_IDLE;
                s_d.line_tx = 1'b1;
            end
        end
        if (s_q.brk) begin
            s_d.line_tx = 1'b0;
        end
        // ------------------------------------------------------------
        // outputs
        // ------------------------------------------------------------
        s_d.rx_serial = rx_level;
        s_d.rx_bit_clk = loop_on ? s_q.ss_clk : tick;
        s_d.rx_enable = !(s_d.one_way_turnaround && s_d.send);
        s_d.loop_mode = (s_d.loop_mode_select != STC_MODE_NORMAL);
        s_d.tx_irq = (s_d.tx_done && s_d.tx_taken_irq_en) ||
                     (s_d.fill_sent_flag && s_d.fill_irq_en);
        // soft clear: hold for CLR_CYC, then reinitialise everything except the fill character
        if (s_q.soft_clear) begin
            if (s_q.clr_cnt == 16'(CLR_CYC - 1)) begin
                s_d = init_state(s_q);
            end else begin
                s_d.clr_cnt = s_q.clr_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s_q <= '{tx_done: 1'b1, tx_holding_buffer: STC_TXB_RST,
                     fill_char: STC_FILL_RST, tx_st: TX_IDLE, line_tx: 1'b1,
                     rx_serial: 1'b1, rx_enable: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign line_tx_o = s_q.line_tx;
    assign rx_serial_o = s_q.rx_serial;
    assign rx_bit_clk_o = s_q.rx_bit_clk;
    assign rx_enable_o = s_q.rx_enable;
    assign loop_mode_o = s_q.loop_mode;
    assign tx_irq_o = s_q.tx_irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    done_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.tx_done && s_q.tx_taken_irq_en |-> tx_irq_o)
        else $error("done with enable gave no request");
    irq_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !s_q.tx_taken_irq_en && !s_q.fill_irq_en |-> !tx_irq_o)
        else $error("request raised while both enables clear");
    fill_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.fill_sent_flag && s_q.fill_irq_en |-> tx_irq_o)
        else $error("fill flag with enable gave no request");
    load_clr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        load && !tick && !s_q.soft_clear |=> !s_q.tx_done)
        else $error("buffer load did not clear done");
    start_done_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.tx_st == TX_DATA && $changed(s_q.buf_full) && !s_q.buf_full |-> s_q.tx_done)
        else $error("first bit out without done");
    hdx_rx_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.one_way_turnaround && s_q.send |-> !rx_enable_o)
        else $error("receiver enabled during one-way send");
    clr_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(s_q.soft_clear) |=> !pready_o [*3] ##[1:700] !s_q.soft_clear)
        else $error("soft clear pulse wrong");
    clr_reset_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(s_q.soft_clear) |-> !s_q.send && !s_q.tx_taken_irq_en && s_q.tx_done
            && s_q.loop_mode_select == STC_MODE_NORMAL)
        else $error("soft clear left state set");
    loop_in_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        loop_on && !s_q.soft_clear |=> rx_serial_o == $past(s_q.loop_serial_input))
        else $error("loop data not routed to receiver");
    idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tick && !s_q.send && s_q.bits_left == 4'h0 && !s_q.soft_clear
            |=> s_q.tx_st == TX_IDLE)
        else $error("transmitter not idle after send cleared");
endmodule

// ---- test/stc_modem.sv ----
`timescale 1ns/100ps
module stc_modem (
    // clock
    input wire logic clk_i,
    // serial line
    input wire logic line_tx_i,
    output logic line_rx_o,
    // bench control
    input wire logic rx_level_i,
    input wire logic clear_i,
    output logic [15:0] low_cnt_o
);
    // modem keeps its data line driven at all times
    assign line_rx_o = rx_level_i;
    // counts space cycles seen on the transmit line
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            low_cnt_o <= 16'h0;
        end else if (line_tx_i == 1'b0) begin
            low_cnt_o <= low_cnt_o + 16'h1;
        end
    end
endmodule

// ---- test/serial_tx_control_status_bench.sv ----
`timescale 1ns/100ps
module serial_tx_control_status_bench import stc_pkg::*; ;
    localparam int BC = 4;
    localparam int CL = 8;
    logic clk_i = 0, nrst_i = 0, psel = 0, penable = 0, pwrite = 0, clr_cnt = 1, rx_lvl = 1;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se, line_tx, line_rx, rx_ser, rx_clk, rx_en, loop_md, irq;
    logic [15:0] low_cnt;
    int err_count = 0, n_tests = 0, cyc, i;
    realtime t0;

    always #2.5 clk_i = ~clk_i;

    stc_txcs #(.BIT_CYC(BC), .CLR_CYC(CL)) stc_txcs_i (.clk_i(clk_i), .nrst_i(nrst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .line_rx_i(line_rx), .line_tx_o(line_tx), .rx_serial_o(rx_ser),
        .rx_bit_clk_o(rx_clk), .rx_enable_o(rx_en), .loop_mode_o(loop_md), .tx_irq_o(irq));
    stc_modem stc_modem_i (.clk_i(clk_i), .line_tx_i(line_tx), .line_rx_o(line_rx),
        .rx_level_i(rx_lvl), .clear_i(clr_cnt), .low_cnt_o(low_cnt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task close_out;
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    // request held until pready is sampled high at a rising edge; only the watchdog ends a wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task settle;
        repeat (2) @(negedge clk_i);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #100000;
        err_count++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdc("csr_reset", STC_TCS_OFF, 32'h0480);
        chk("tx_idle", 32'h1, {31'h0, line_tx});
        rdc("txbuf_read", STC_TXB_OFF, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h1, {31'h0, se});
        // writable bits in every loop mode, monitor follows the selected input
        rx_lvl <= 1'b0;
        for (i = 0; i < 4; i++) begin
            apb(1'b1, STC_TCS_OFF, 32'h6018 | (i << 11));
            settle();
            apb(1'b0, STC_TCS_OFF, 32'h0);
            chk("csr_rw", 32'h6098 | (i << 11) | ((i == 1 || i == 2) ? 32'h400 : 32'h0),
                (i == 3) ? (rd & ~32'h400) : rd);
            chk("rx_enable", 32'h0, {31'h0, rx_en});
            chk("loop_mode", {31'h0, i != 0}, {31'h0, loop_md});
            if (i == 1 || i == 2) begin
                chk("rx_serial", 32'h1, {31'h0, rx_ser});
                chk("rx_clock", 32'h1, {31'h0, rx_clk});
            end
        end
        apb(1'b1, STC_TCS_OFF, 32'h0008);
        settle();
        chk("rx_enable_idle", 32'h1, {31'h0, rx_en});
        chk("rx_serial_line", 32'h0, {31'h0, rx_ser});
        @(posedge clk_i);
        rx_lvl <= 1'b1;
        // load without send: no transmission, done stays clear
        apb(1'b1, STC_TCS_OFF, 32'h0040);
        apb(1'b1, STC_TXB_OFF, 32'h005a);
        repeat (4 * BC) @(negedge clk_i);
        rdc("done_cleared", STC_TCS_OFF, 32'h0440);
        chk("no_start", 32'h1, {31'h0, line_tx});
        clr_cnt <= 1'b0;
        apb(1'b1, STC_TCS_OFF, 32'h0050);
        cyc = 0;
        while (irq !== 1'b1 && cyc < 8 * BC) begin
            @(negedge clk_i);
            cyc++;
        end
        chk("first_bit", 32'h0, {31'h0, line_tx});
        chk("done_irq", 32'h1, {31'h0, irq});
        // send dropped mid character: finish it, then idle with no fill
        apb(1'b1, STC_TCS_OFF, 32'h0040);
        repeat (12 * BC) @(negedge clk_i);
        chk("space_cycles", 4 * BC, {16'h0, low_cnt});
        chk("idle_after", 32'h1, {31'h0, line_tx});
        rdc("done_set", STC_TCS_OFF, 32'h04c0);
        apb(1'b1, STC_TCS_OFF, 32'h0);
        settle();
        chk("irq_gated", 32'h0, {31'h0, irq});
        // late next character: fill goes out, fill flag raises request
        apb(1'b1, STC_TCS_OFF, 32'h0030);
        apb(1'b1, STC_TXB_OFF, 32'h0000);
        repeat (3 * BC) @(negedge clk_i);
        rdc("done_no_ie", STC_TCS_OFF, 32'h04b0);
        chk("irq_quiet", 32'h0, {31'h0, irq});
        cyc = 0;
        while (irq !== 1'b1 && cyc < 24 * BC) begin
            @(negedge clk_i);
            cyc++;
        end
        chk("fill_irq", 32'h1, {31'h0, irq});
        rdc("fill_flag", STC_TCS_OFF, 32'h84b0);
        // soft clear stalls the bus, then everything but the fill character is back to reset
        apb(1'b1, STC_TCS_OFF, 32'h7878);
        t0 = $realtime;
        apb(1'b1, STC_TCS_OFF, 32'h0100);
        rdc("csr_after_clear", STC_TCS_OFF, 32'h0480);
        chk("clear_stall", 32'h1, {31'h0, ($realtime - t0) >= CL * 5.0});
        chk("irq_after_clear", 32'h0, {31'h0, irq});
        close_out();
    end
endmodule
